/* design/ssp_pkg.sv */
/*
 SPI port package: register offsets, field positions, reset values, mode codes,
 carrier structs. Assumes a 32-bit AHB-Lite register bus.
*/
package ssp_pkg;
   localparam logic [7:0] SSP_OFF_STATUS  = 8'h00;
   localparam logic [7:0] SSP_OFF_CTRL    = 8'h04;
   localparam logic [7:0] SSP_OFF_BUFFER  = 8'h08;
   localparam logic [7:0] SSP_OFF_SYS     = 8'h0c;

   localparam int SSP_STAT_SMP  = 7;
   localparam int SSP_STAT_CKE  = 6;
   localparam int SSP_STAT_STOP = 4;
   localparam int SSP_STAT_BF   = 0;
   localparam int SSP_CTRL_WRITE_COLLISION_FLAG = 7;
   localparam int SSP_CTRL_OV   = 6;
   localparam int SSP_CTRL_EN   = 5;
   localparam int SSP_CTRL_CKP  = 4;

   localparam logic [7:0] SSP_STATUS_RST = 8'h00;
   localparam logic [7:0] SSP_CTRL_RST   = 8'h00;

   localparam logic [3:0] SSP_MODE_DIV4   = 4'h0;
   localparam logic [3:0] SSP_MODE_DIV16  = 4'h1;
   localparam logic [3:0] SSP_MODE_DIV64  = 4'h2;
   localparam logic [3:0] SSP_MODE_TIMER_TWO_OUTPUT   = 4'h3;
   localparam logic [3:0] SSP_MODE_SLV_SS = 4'h4;
   localparam logic [3:0] SSP_MODE_SLV    = 4'h5;

   // Half-period counts less one, in system clocks, per serial clock phase
   localparam logic [5:0] SSP_HALF_DIV4  = 6'h01;
   localparam logic [5:0] SSP_HALF_DIV16 = 6'h07;
   localparam logic [5:0] SSP_HALF_DIV64 = 6'h1f;
   localparam logic [3:0] SSP_BITS       = 4'h8;

   typedef enum logic [1:0] {
      SSP_IDLE,
      SSP_LEAD,
      SSP_TRAIL
   } ssp_state_e;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
   } ssp_pin_out_s;

   typedef struct packed {
      logic sck_i;
      logic sdi_i;
      logic ss_n_i;
   } ssp_pin_in_s;
endpackage

/* design/ssp_port.sv */
/*
 Byte-wide SPI master/slave with AHB-Lite register slave.
 Assumes one AHB-Lite master, pins buffered outside, timer-two pulse input.
*/
`timescale 1ns/100ps
module ssp_port
   import ssp_pkg::*;
(
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         hsel_i,
   input  wire logic [31:0]  haddr_i,
   input  wire logic [1:0]   htrans_i,
   input  wire logic         hwrite_i,
   input  wire logic [2:0]   hsize_i,
   input  wire logic [31:0]  hwdata_i,
   input  wire logic         hready_i,
   output logic      [31:0]  hrdata_o,
   output logic              hreadyout_o,
   output logic              hresp_o,
   input  wire logic         timer_two_output_i,
   input  wire ssp_pin_in_s  pin_i,
   output ssp_pin_out_s      pin_o,
   output logic              port_enable_o,
   output logic              port_interrupt_o,
   output logic              wake_o
);
   logic [7:0]  stat_q;
   logic [7:0]  ctrl_q;
   logic [7:0]  spi_buffer_q;
   logic [7:0]  spi_shift_register_q;
   logic        sdo_disable_q;
   logic        irq_q;
   logic        wake_q;
   logic        wr_ph_q;
   logic        rd_ph_q;
   logic [7:0]  addr_q;
   ssp_state_e  st_q;
   logic [5:0]  div_q;
   logic [3:0]  cnt_q;
   logic        sck_q;
   logic        sdo_q;
   logic        smp_bit_q;
   logic [1:0]  sck_sync_q;
   logic [1:0]  ss_sync_q;
   logic        sck_prev_q;
   logic        t2_prev_q;

   wire logic [3:0] mode     = ctrl_q[3:0];
   wire logic       en       = ctrl_q[SSP_CTRL_EN];
   wire logic       clock_polarity      = ctrl_q[SSP_CTRL_CKP];
   wire logic       cke      = stat_q[SSP_STAT_CKE];
   wire logic       input_sample_select      = stat_q[SSP_STAT_SMP];
   wire logic       master   = en && (mode <= SSP_MODE_TIMER_TWO_OUTPUT);
   wire logic       slave    = en && (mode == SSP_MODE_SLV_SS || mode == SSP_MODE_SLV);
   wire logic       ss_use   = mode == SSP_MODE_SLV_SS;
   wire logic       ss_off   = slave && ss_use && ss_sync_q[1];
   wire logic       busy     = (st_q != SSP_IDLE) || (slave && cnt_q != 4'h0);

   // AHB-Lite slave: zero wait states, always OKAY
   wire logic       take     = hsel_i && hready_i && htrans_i[1];
   wire logic       buf_wr   = wr_ph_q && addr_q == SSP_OFF_BUFFER;
   wire logic       buf_rd   = rd_ph_q && addr_q == SSP_OFF_BUFFER;
   wire logic       ctrl_wr  = wr_ph_q && addr_q == SSP_OFF_CTRL;
   wire logic       stat_wr  = wr_ph_q && addr_q == SSP_OFF_STATUS;
   wire logic       sys_wr   = wr_ph_q && addr_q == SSP_OFF_SYS;

   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_ph_q <= 1'b0;
         rd_ph_q <= 1'b0;
         addr_q  <= 8'h00;
      end
      else
      begin
         wr_ph_q <= take && hwrite_i;
         rd_ph_q <= take && !hwrite_i;
         if (take)
            addr_q <= {haddr_i[7:2], 2'b00};
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         hrdata_o <= 32'h0000_0000;
      else if (take && !hwrite_i)
      begin
         unique case ({haddr_i[7:2], 2'b00})
            SSP_OFF_STATUS: hrdata_o <= {24'h00_0000, stat_q};
            SSP_OFF_CTRL:   hrdata_o <= {24'h00_0000, ctrl_q};
            SSP_OFF_BUFFER: hrdata_o <= {24'h00_0000, spi_buffer_q};
            SSP_OFF_SYS:    hrdata_o <= {30'h0000_0000, irq_q, sdo_disable_q};
            default:        hrdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // Synchronisers: first stage feeds only the second
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         sck_sync_q <= 2'b00;
         ss_sync_q  <= 2'b11;
         sck_prev_q <= 1'b0;
         t2_prev_q  <= 1'b0;
      end
      else
      begin
         sck_sync_q <= {sck_sync_q[0], pin_i.sck_i};
         ss_sync_q  <= {ss_sync_q[0], pin_i.ss_n_i};
         sck_prev_q <= sck_sync_q[1];
         t2_prev_q  <= timer_two_output_i;
      end
   end

   // Slave edges relative to idle level; leading edge leaves idle
   wire logic s_rise   = sck_sync_q[1] && !sck_prev_q;
   wire logic s_fall   = !sck_sync_q[1] && sck_prev_q;
   wire logic s_lead   = clock_polarity ? s_fall : s_rise;
   wire logic s_trail  = clock_polarity ? s_rise : s_fall;
   wire logic s_active = slave && !ss_off;
   // CKE set: out on trailing, in on leading; clear: the reverse
   wire logic s_sample = s_active && (cke ? s_lead : s_trail);
   wire logic s_shift  = s_active && (cke ? s_trail : s_lead);

   // Master tick: one half period per tick
   logic tick;
   always_comb
   begin
      unique case (mode)
         SSP_MODE_DIV4:  tick = div_q == SSP_HALF_DIV4;
         SSP_MODE_DIV16: tick = div_q == SSP_HALF_DIV16;
         SSP_MODE_DIV64: tick = div_q == SSP_HALF_DIV64;
         SSP_MODE_TIMER_TWO_OUTPUT:  tick = timer_two_output_i && !t2_prev_q;
         default:        tick = 1'b0;
      endcase
   end

   wire logic m_start = master && buf_wr && st_q == SSP_IDLE;
   wire logic m_done  = st_q == SSP_TRAIL && tick && cnt_q == SSP_BITS - 4'h1;
   wire logic s_done  = s_sample && cnt_q == SSP_BITS - 4'h1;
   // Master sample point: middle is the edge opposite the shift edge.
   // End is the trailing tick; with edge select clear no later tick
   // exists for the last bit, so end and middle coincide there.
   logic m_late;
   logic m_samp;
   logic m_in;
   always_comb
   begin
      m_late = input_sample_select || !cke;
      m_samp = 1'b0;
      if (!m_late)
         m_samp = st_q == SSP_LEAD && tick;
      m_in   = m_late ? pin_i.sdi_i : smp_bit_q;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || !master || st_q == SSP_IDLE || tick)
         div_q <= 6'h00;
      else
         div_q <= div_q + 6'h01;
   end

   // Master state machine: LEAD = first half of a bit, TRAIL = second
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || !master)
      begin
         st_q  <= SSP_IDLE;
         sck_q <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            SSP_IDLE:
               if (m_start)
                  st_q <= SSP_LEAD;
            SSP_LEAD:
               if (tick)
               begin
                  st_q  <= SSP_TRAIL;
                  sck_q <= 1'b1;
               end
            SSP_TRAIL:
               if (tick)
               begin
                  st_q  <= m_done ? SSP_IDLE : SSP_LEAD;
                  sck_q <= 1'b0;
               end
         endcase
      end
   end

   // Bit counter, shift register and sampled input bit
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || !en || ss_off)
      begin
         cnt_q     <= 4'h0;
         smp_bit_q <= 1'b0;
      end
      else if (master)
      begin
         if (m_samp)
            smp_bit_q <= pin_i.sdi_i;
         if (st_q == SSP_TRAIL && tick)
            cnt_q <= m_done ? 4'h0 : cnt_q + 4'h1;
      end
      else if (s_sample)
         cnt_q <= s_done ? 4'h0 : cnt_q + 4'h1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         spi_shift_register_q <= 8'h00;
      else if (buf_wr && !busy)
         spi_shift_register_q <= hwdata_i[7:0];
      else if (master && st_q == SSP_TRAIL && tick)
         spi_shift_register_q <= {spi_shift_register_q[6:0], m_in};
      else if (s_sample)
         spi_shift_register_q <= {spi_shift_register_q[6:0], pin_i.sdi_i};
   end

   // Data out: CKE set presents MSB before first edge
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         sdo_q <= 1'b0;
      else if (buf_wr && !busy)
         sdo_q <= hwdata_i[7];
      else if (master && tick && (cke ? st_q == SSP_TRAIL : st_q == SSP_LEAD))
         sdo_q <= cke ? spi_shift_register_q[6] : spi_shift_register_q[7];
      // Slave sample has already moved the next bit to the top
      else if (s_shift)
         sdo_q <= spi_shift_register_q[7];
   end

   wire logic byte_done = (m_done || s_done) && !(s_done && stat_q[SSP_STAT_BF]);

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         spi_buffer_q <= 8'h00;
      else if (buf_wr && !busy)
         spi_buffer_q <= hwdata_i[7:0];
      else if (m_done)
         spi_buffer_q <= {spi_shift_register_q[6:0], m_in};
      else if (byte_done)
         spi_buffer_q <= {spi_shift_register_q[6:0], pin_i.sdi_i};
   end

   // Status: INPUT_SAMPLE_SELECT and CKE writable, stop and BF hardware owned
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         stat_q <= SSP_STATUS_RST;
      else
      begin
         if (stat_wr)
         begin
            stat_q[SSP_STAT_SMP] <= hwdata_i[SSP_STAT_SMP];
            stat_q[SSP_STAT_CKE] <= hwdata_i[SSP_STAT_CKE];
         end
         if (!en)
            stat_q[SSP_STAT_STOP] <= 1'b0;
         // Set wins over a same-cycle read
         if (byte_done)
            stat_q[SSP_STAT_BF] <= 1'b1;
         else if (buf_rd)
            stat_q[SSP_STAT_BF] <= 1'b0;
      end
   end

   // Control: collision and overflow are sticky; software writes zero to clear
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         ctrl_q <= SSP_CTRL_RST;
      else
      begin
         if (ctrl_wr)
            ctrl_q <= hwdata_i[7:0];
         if (buf_wr && busy)
            ctrl_q[SSP_CTRL_WRITE_COLLISION_FLAG] <= 1'b1;
         if (s_done && stat_q[SSP_STAT_BF])
            ctrl_q[SSP_CTRL_OV] <= 1'b1;
      end
   end

   // Extra control: data-out disable, interrupt flag (write one to clear)
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         sdo_disable_q <= 1'b0;
         irq_q         <= 1'b0;
         wake_q        <= 1'b0;
      end
      else
      begin
         if (sys_wr)
            sdo_disable_q <= hwdata_i[0];
         if (byte_done)
            irq_q <= 1'b1;
         else if (sys_wr && hwdata_i[1])
            irq_q <= 1'b0;
         wake_q <= s_done;
      end
   end

   // Pin ownership; reserved modes leave pins undriven
   always_comb
   begin
      pin_o.sck_o  = master ? (sck_q ^ clock_polarity) : clock_polarity;
      pin_o.sck_oe = master;
      pin_o.sdo_o  = sdo_q;
      pin_o.sdo_oe = (master || (slave && !ss_off)) && !sdo_disable_q;
   end

   assign port_enable_o    = en;
   assign port_interrupt_o = irq_q;
   assign wake_o           = wake_q;
endmodule // ssp_port

/* verification/ssp_far_slave.sv */
/*
 Far-side SPI slave model for the master-mode tests.
 Assumes the bench sets its polarity and edge to match the port.
*/
`timescale 1ns/100ps
module ssp_far_slave (
   input  wire logic       sck_i,
   input  wire logic       sdo_i,
   input  wire logic       ckp_i,
   input  wire logic       cke_i,
   input  wire logic       load_i,
   input  wire logic [7:0] tx_i,
   output logic            sdi_o,
   output logic [7:0]      rx_o
);
   logic [7:0] sh;
   int         n;
   initial sdi_o = 1'b0;
   always @(load_i)
   begin
      sh = tx_i;
      n = 0;
      sdi_o <= #1 cke_i ? tx_i[7] : ~sdi_o;
   end
   always @(sck_i)
   begin
      if ((sck_i != ckp_i) ^ cke_i) // Shift-out edge
      begin
         sdi_o <= #1 (n < 8) ? sh[7 - cke_i] : ~sdi_o; // Not held after frame
         sh = sh << 1;
      end
      else
      begin
         rx_o = {rx_o[6:0], sdo_i}; // Latch on the other edge
         n = n + 1;
      end
   end
endmodule // ssp_far_slave

/* verification/ssp_port_sva.sv */
/*
 Checker for the SPI port, bound to its ports.
 Assumes control is only written through the bus.
*/
`timescale 1ns/100ps
module ssp_port_sva
   import ssp_pkg::*;
(
   input wire logic         sys_clk_i,
   input wire logic         sys_rst_i,
   input wire logic         hsel_i,
   input wire logic [31:0]  haddr_i,
   input wire logic [1:0]   htrans_i,
   input wire logic         hwrite_i,
   input wire logic [2:0]   hsize_i,
   input wire logic [31:0]  hwdata_i,
   input wire logic         hready_i,
   input wire logic [31:0]  hrdata_o,
   input wire logic         hreadyout_o,
   input wire logic         hresp_o,
   input wire logic         timer_two_output_i,
   input wire ssp_pin_in_s  pin_i,
   input wire ssp_pin_out_s pin_o,
   input wire logic         port_enable_o,
   input wire logic         port_interrupt_o,
   input wire logic         wake_o
);
   logic       wr_q;
   logic [7:0] off_q;
   logic [4:0] ctl_q;
   logic       mst;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   assign mst = port_enable_o && ctl_q[3:0] <= SSP_MODE_TIMER_TWO_OUTPUT;
   // Shadow of polarity and mode, taken when the write lands
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_q  <= 1'b0;
         off_q <= 8'h00;
         ctl_q <= 5'h00;
      end
      else
      begin
         wr_q  <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
         off_q <= haddr_i[7:0];
         if (wr_q && off_q == SSP_OFF_CTRL)
            ctl_q <= hwdata_i[4:0];
      end
   end
   a_pins_released: assert property (!port_enable_o |-> !pin_o.sck_oe && !pin_o.sdo_oe)
      else $error("pins driven while disabled");
   a_master_clk_out: assert property (mst |-> pin_o.sck_oe)
      else $error("master clock not driven");
   a_slave_clk_in: assert property (port_enable_o && ctl_q[3:1] == 3'h2 |-> !pin_o.sck_oe)
      else $error("slave drives clock");
   a_reserved_quiet: assert property (port_enable_o && ctl_q[3:0] > SSP_MODE_SLV
      |-> !pin_o.sck_oe && !pin_o.sdo_oe && !wake_o) else $error("reserved mode active");
   a_div16_half: assert property (mst && ctl_q[3:0] == SSP_MODE_DIV16
      && $changed(pin_o.sck_o) && pin_o.sck_o != ctl_q[4] |=> $stable(pin_o.sck_o)[*7]
      ##1 $changed(pin_o.sck_o)) else $error("wrong half period");
   a_wake_single: assert property (wake_o |=> !wake_o)
      else $error("wake longer than one cycle");
   a_wake_flags: assert property (wake_o |-> ##[0:1] port_interrupt_o)
      else $error("wake without interrupt flag");
   a_irq_sticky: assert property (port_interrupt_o && !(wr_q && off_q == SSP_OFF_SYS)
      |=> port_interrupt_o) else $error("interrupt flag dropped");
   a_select_release: assert property (port_enable_o && ctl_q[3:0] == SSP_MODE_SLV_SS
      && pin_i.ss_n_i[*4] |-> !pin_o.sdo_oe) else $error("data out held while deselected");
   cover property (wake_o);
   cover property (mst && ctl_q[3:0] == SSP_MODE_DIV16 && $rose(port_interrupt_o));
   cover property (ctl_q[3:0] == SSP_MODE_SLV_SS && $rose(pin_i.ss_n_i));
endmodule // ssp_port_sva
bind ssp_port ssp_port_sva i_sva (.*);

/* verification/ssp_port_tb.sv */
/*
 Self-checking bench for the SPI port; bus reads are scored from a queue.
 Assumes the far-slave model and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module ssp_port_tb
   import ssp_pkg::*;
;
   logic         clk = 0, rst = 1, hsel = 0, hwrite = 0, t2 = 0, clock_polarity = 0, cke = 0;
   logic         load = 0, slv = 0, e_sck = 0, e_sdi = 0, e_ss_n = 1, rd_ph = 0;
   logic [1:0]   htrans = 0;
   logic [2:0]   hsize = 3'b010;
   logic [31:0]  haddr = 0, hwdata = 0, hrdata, v;
   logic         hrdy, hresp, pen, irq, wake, sck_w, far_sdi;
   logic [7:0]   tx, px, rx, far_rx, b;
   ssp_pin_in_s  pin_in;
   ssp_pin_out_s pin_out;
   logic [31:0]  exp_q[$], msk_q[$];
   int           seed = 28, mismatches = 0, n_compared = 0, n;
   ssp_port i_dut (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .timer_two_output_i(t2), .pin_i(pin_in), .pin_o(pin_out), .port_enable_o(pen),
      .port_interrupt_o(irq), .wake_o(wake));
   ssp_far_slave i_far (.sck_i(sck_w), .sdo_i(pin_out.sdo_oe ? pin_out.sdo_o : 1'b1),
      .ckp_i(clock_polarity), .cke_i(cke), .load_i(load), .tx_i(px), .sdi_o(far_sdi), .rx_o(far_rx));
   assign sck_w  = pin_out.sck_oe ? pin_out.sck_o : clock_polarity;
   assign pin_in = slv ? {e_sck, e_sdi, e_ss_n} : {sck_w, far_sdi, 1'b1};
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      v = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus(a, 1'b0, 32'h0);
   endtask
   // External master, half period of six cycles to clear the synchroniser
   task automatic ext(input logic [7:0] d, input int nb, input logic s);
      // Let a select raised by the previous call reach the synchroniser
      repeat (4) @(posedge clk);
      e_ss_n <= s;
      for (int k = 7; k > 7 - nb; k--)
      begin
         repeat (6) @(posedge clk);
         e_sdi <= d[k];
         e_sck <= 1'b1;
         repeat (6) @(posedge clk);
         rx = {rx[6:0], pin_out.sdo_o};
         e_sck <= 1'b0;
      end
      repeat (6) @(posedge clk);
      e_ss_n <= 1'b1;
      e_sdi  <= ~e_sdi;
   endtask
   task automatic finish_test;
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      if (rd_ph && exp_q.size() > 0)
         chk("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
      rd_ph <= hsel && hrdy && htrans[1] && !hwrite;
      t2    <= 1'($random(seed));
   end
   initial
   begin
      forever #2 clk = ~clk;
   end
   initial
   begin
      #300000;
      mismatches++;
      finish_test;
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(SSP_OFF_STATUS, {24'h0, SSP_STATUS_RST}, '1);
      rd(SSP_OFF_CTRL, {24'h0, SSP_CTRL_RST}, '1);
      wr(8'h10, '1);
      rd(8'h10, 32'h0, '1);
      for (int i = 0; i < 8; i++)
      begin
         clock_polarity <= i[0];
         cke <= i[2];
         wr(SSP_OFF_CTRL, 32'h0);
         wr(SSP_OFF_STATUS, {24'h0, i[1], i[2], 6'h0});
         wr(SSP_OFF_SYS, {31'h0, i == 5});
         wr(SSP_OFF_CTRL, {24'h0, 2'b00, 1'b1, i[0], 2'b00, i[1:0]});
         tx = 8'($random(seed));
         px = 8'($random(seed));
         load <= ~load;
         wr(SSP_OFF_BUFFER, {24'h0, tx});
         wr(SSP_OFF_BUFFER, {24'h0, ~tx});
         n = 0;
         do
         begin
            rd(SSP_OFF_STATUS, 32'h0, 32'h0);
            n++;
         end
         while (v[0] !== 1'b1 && n < 400);
         rd(SSP_OFF_STATUS, {24'h0, i[1], i[2], 6'h1}, 32'hff);
         rd(SSP_OFF_BUFFER, {24'h0, px}, '1);
         rd(SSP_OFF_STATUS, {24'h0, i[1], i[2], 6'h0}, 32'hff);
         rd(SSP_OFF_CTRL, {24'h0, 3'b101, i[0], 2'b00, i[1:0]}, '1);
         if (i != 5)
            chk("far rx", {24'h0, far_rx}, {24'h0, tx});
         chk("sck idle", {31'h0, pin_out.sck_o}, {31'h0, i[0]});
         chk("irq", {31'h0, irq}, 32'h1);
         wr(SSP_OFF_SYS, 32'h2);
         #1;
         chk("irq clear", {31'h0, irq}, 32'h0);
      end
      wr(SSP_OFF_CTRL, 32'h0);
      wr(SSP_OFF_CTRL, 32'h26);
      wr(SSP_OFF_BUFFER, 32'h5a);
      repeat (100) @(posedge clk);
      rd(SSP_OFF_STATUS, 32'h0, 32'h1);
      wr(SSP_OFF_CTRL, 32'h0);
      wr(SSP_OFF_STATUS, 32'h0); // Sample and edge select clear
      slv <= 1'b1; // Clock already idle low
      wr(SSP_OFF_CTRL, 32'h24);
      wr(SSP_OFF_BUFFER, 32'h3c);
      b = 8'($random(seed));
      ext(b, 8, 1'b0);
      chk("slave out", {24'h0, rx}, 32'h3c);
      chk("irq slave", {31'h0, irq}, 32'h1);
      rd(SSP_OFF_BUFFER, {24'h0, b}, '1);
      b = 8'($random(seed));
      ext(b, 8, 1'b0);
      ext(~b, 8, 1'b0);
      rd(SSP_OFF_CTRL, 32'h64, '1);
      rd(SSP_OFF_BUFFER, {24'h0, b}, '1);
      wr(SSP_OFF_CTRL, 32'h24);
      ext(8'hff, 3, 1'b0); // Select rises mid-byte
      b = 8'($random(seed));
      ext(b, 8, 1'b0);
      rd(SSP_OFF_BUFFER, {24'h0, b}, '1);
      wr(SSP_OFF_CTRL, 32'h0);
      wr(SSP_OFF_CTRL, 32'h25);
      b = 8'($random(seed));
      ext(b, 8, 1'b1);
      rd(SSP_OFF_BUFFER, {24'h0, b}, '1);
      repeat (2) @(posedge clk);
      finish_test;
   end
endmodule // ssp_port_tb
